// ---- rtl/iacd_ctrl.sv ----
`timescale 1ns/1ps
module iacd_ctrl #(
  parameter int unsigned HALF_CYC = iacd_pkg::SCL_HALF_CYC
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_io_sel,
  input  wire logic                        i_io_we,
  input  wire logic [iacd_pkg::REG_AW-1:0] i_io_addr,
  input  wire logic [15:0]                 i_io_wdata,
  output logic      [15:0]                 o_io_rdata,
  input  wire logic                        i_master,
  input  wire logic                        i_start_req,
  input  wire logic                        i_transmit_select,
  input  wire logic                        i_free_format_select,
  input  wire logic                        i_extended_address_select,
  input  wire logic                        i_repeat_mode_select,
  input  wire logic                        i_stop_request,
  input  wire logic [2:0]                  i_bit_length_field,
  output logic                             o_addressed_as_slave_flag,
  output logic                             o_rx_ready,
  output logic                             o_tx_ready,
  output logic                             o_bus_busy,
  input  wire logic                        i_scl,
  output logic                             o_scl_o,
  output logic                             o_scl_oe,
  input  wire logic                        i_sda,
  output logic                             o_sda_o,
  output logic                             o_sda_oe
);
  import iacd_pkg::*;

  localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);

  logic [ADDR_W-1:0] sar_q, oar_q;
  logic [15:0]       cnt_q, rdata_q;
  logic [16:0]       cnt_int_q;
  logic [DATA_W-1:0] drr_q, dxr_q;
  logic              dxr_full_q, rx_rdy_q, aas_q, busy_q;
  logic [2:0]        scl_s_q, sda_s_q;
  logic [15:0]       div_q;
  iacd_mst_t         m_q, m_d;
  iacd_kind_t        kind_q, ld_kind;
  logic              eng_q, ack_ph_q, tx_q, slave_q, nack_q, stp_ph_q, stp_ph_d;
  logic [3:0]        bit_q;
  logic              scl_oe_q, scl_d, sda_oe_q, sda_d;
  logic              ld, ld_tx, ld_slave, ld_dxr, want_data;
  logic [7:0]        ld_val;
  logic [7:0]        sh_data;
  logic              sh_msb;

  // [0] is the metastable stage, only [1] and [2] feed logic
  wire scl_now   = scl_s_q[1];
  wire scl_old   = scl_s_q[2];
  wire sda_now   = sda_s_q[1];
  wire sda_old   = sda_s_q[2];
  wire scl_rise  = scl_now & ~scl_old;
  wire scl_fall  = ~scl_now & scl_old;
  wire start_det = scl_now & scl_old & sda_old & ~sda_now;
  wire stop_det  = scl_now & scl_old & ~sda_old & sda_now;

  wire xa     = i_extended_address_select;
  wire wr     = i_io_sel & i_io_we;
  wire rd     = i_io_sel & ~i_io_we;
  wire wr_sar = wr & (i_io_addr == REG_TARGET_ADDR);
  wire wr_oar = wr & (i_io_addr == REG_OWN_ADDR);
  wire wr_cnt = wr & (i_io_addr == REG_BYTE_COUNT);
  wire wr_dxr = wr & (i_io_addr == REG_TX_DATA);
  wire rd_drr = rd & (i_io_addr == REG_RX_DATA);
  wire [16:0] cnt_load = (i_io_wdata == 16'h0000) ? COUNT_FULL : {1'b0, i_io_wdata};

  // shifters are not on this mux, only the holding registers
  wire [15:0] rd_mux =
    (i_io_addr == REG_TARGET_ADDR) ? {6'h00, sar_q} :
    (i_io_addr == REG_OWN_ADDR)    ? {6'h00, oar_q} :
    (i_io_addr == REG_BYTE_COUNT)  ? cnt_q :
    (i_io_addr == REG_RX_DATA)     ? {8'h00, drr_q} :
    (i_io_addr == REG_TX_DATA)     ? {8'h00, dxr_q} : 16'h0000;

  wire [3:0] data_bits = (i_bit_length_field == 3'h0) ? 4'h8 : {1'b0, i_bit_length_field};
  wire [3:0] nb        = (kind_q == K_DATA) ? data_bits : 4'h8;
  // software right-aligns short bytes; move them up so the msb goes first
  wire [7:0] tx_just   = dxr_q << (4'h8 - data_bits);
  wire       gen_call  = ~xa & (sar_q[6:0] == 7'h00);
  wire [7:0] addr1_byte = xa ? {TEN_BIT_PREFIX, sar_q[9:8], 1'b0}
                             : {sar_q[6:0], ~i_transmit_select & ~gen_call};

  wire bits_done = (bit_q == nb);
  wire run_fall  = eng_q & scl_fall;
  wire sh_shift  = eng_q & scl_rise & ~ack_ph_q;
  wire enter_ack = run_fall & ~ack_ph_q & bits_done;
  wire byte_end  = run_fall & ack_ph_q;
  wire m_end     = byte_end & ~slave_q;
  wire s_end     = byte_end & slave_q;
  wire cnt_done  = ~i_repeat_mode_select & (cnt_int_q == 17'h0);
  wire cnt_last  = ~i_repeat_mode_select & (cnt_int_q == 17'h1);
  wire stop_now  = i_stop_request & (i_repeat_mode_select | (cnt_int_q == 17'h1));
  wire cnt_dec   = m_end & tx_q & (kind_q == K_DATA) & ~i_repeat_mode_select
                   & (cnt_int_q != 17'h0);
  wire tick      = (div_q == HALF_M1);
  wire rx_copy   = enter_ack & ~tx_q & (kind_q == K_DATA);

  function automatic logic addr_hit(input logic [7:0] b, input logic [9:0] own,
                                    input logic ten, input iacd_kind_t k);
    if (k == K_ADDR2) begin
      addr_hit = (b == own[7:0]);
    end else if (ten) begin
      addr_hit = (b[7:3] == TEN_BIT_PREFIX) && (b[2:1] == own[9:8]) && !b[0];
    end else begin
      // slave side is receive only: a read request is not answered
      addr_hit = !b[0] && ((b[7:1] == own[6:0]) || (b[7:1] == 7'h00));
    end
  endfunction : addr_hit

  wire s_hit   = addr_hit(sh_data, oar_q, xa, kind_q);
  wire s_ack   = ~slave_q | (kind_q == K_DATA) | addr_hit(sh_data, oar_q, xa, kind_q);
  wire rx_ack  = ~tx_q & s_ack;
  wire aas_set = s_end & s_hit & ((kind_q == K_ADDR2) | ((kind_q == K_ADDR1) & ~xa));
  wire aas_clr = stop_det | (start_det & ~xa)
               | (s_end & nack_q)
               | (s_end & xa & ~s_hit & (kind_q != K_DATA));

  always_comb begin
    m_d       = m_q;
    stp_ph_d  = stp_ph_q;
    ld        = 1'b0;
    ld_val    = 8'h00;
    ld_tx     = 1'b0;
    ld_kind   = K_DATA;
    ld_slave  = 1'b0;
    ld_dxr    = 1'b0;
    want_data = 1'b0;
    case (m_q)
      M_IDLE: begin
        if (i_start_req & i_master & ~busy_q) begin
          m_d = M_START;
        end else if (start_det) begin
          ld       = 1'b1;
          ld_slave = 1'b1;
          ld_kind  = K_ADDR1;
        end else if (s_end & ((kind_q == K_DATA) | s_hit)) begin
          ld       = 1'b1;
          ld_slave = 1'b1;
          ld_kind  = ((kind_q == K_ADDR1) & xa) ? K_ADDR2 : K_DATA;
        end
      end
      M_START: begin
        if (tick & ~i_free_format_select) begin
          ld      = 1'b1;
          ld_tx   = 1'b1;
          ld_kind = K_ADDR1;
          ld_val  = addr1_byte;
          m_d     = M_BYTE;
        end else if (tick) begin
          want_data = 1'b1;
        end
      end
      M_BYTE: begin
        if (m_end) begin
          if (tx_q & nack_q) begin
            m_d = M_STOP;
          end else if ((kind_q == K_ADDR1) & xa) begin
            ld      = 1'b1;
            ld_tx   = 1'b1;
            ld_kind = K_ADDR2;
            ld_val  = sar_q[7:0];
          end else if (kind_q != K_DATA) begin
            want_data = 1'b1;
          end else if (i_transmit_select & stop_now) begin
            m_d = M_STOP;
          end else if (i_transmit_select & cnt_last) begin
            m_d = M_HOLD;
          end else if (~i_transmit_select & i_stop_request) begin
            m_d = M_STOP;
          end else begin
            want_data = 1'b1;
          end
        end
      end
      M_HOLD: begin
        if (i_stop_request & (i_repeat_mode_select | cnt_done)) begin
          m_d = M_STOP;
        end else if (~cnt_done) begin
          want_data = 1'b1;
        end
      end
      M_STOP: begin
        if (tick) begin
          stp_ph_d = ~stp_ph_q;
          if (stp_ph_q) begin
            m_d = M_IDLE;
          end
        end
      end
      default: m_d = M_IDLE;
    endcase
    if (want_data) begin
      // transmit waits with scl held low until a byte is written
      ld     = ~i_transmit_select | dxr_full_q;
      ld_tx  = i_transmit_select;
      ld_dxr = i_transmit_select;
      ld_val = i_transmit_select ? tx_just : 8'h00;
      m_d    = ld ? M_BYTE : M_HOLD;
    end
  end

  always_comb begin
    sda_d = sda_oe_q;
    scl_d = scl_oe_q;
    if (run_fall & ~ack_ph_q & ~bits_done) sda_d = tx_q & ~sh_msb;
    if (enter_ack) sda_d = rx_ack;
    if (byte_end) sda_d = 1'b0;
    if (ld) sda_d = ld_tx & ~ld_val[7];
    if (m_d == M_START) sda_d = 1'b1;
    if ((m_d == M_STOP) & (m_q != M_STOP)) sda_d = 1'b1;
    if ((m_q == M_STOP) & tick & stp_ph_q) sda_d = 1'b0;
    if ((m_q == M_START) & tick) scl_d = 1'b1;
    // a slave holding scl low stretches the low phase
    if ((m_q == M_BYTE) & tick & (scl_oe_q | scl_now)) scl_d = ~scl_oe_q;
    if ((m_q == M_STOP) & tick & ~stp_ph_q) scl_d = 1'b0;
  end

  iacd_shift #(.W(DATA_W)) u_shift (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_load     (ld),
    .i_load_val (ld_val),
    .i_shift    (sh_shift),
    .i_bit      (sda_now),
    .o_data     (sh_data),
    .o_msb      (sh_msb)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sar_q <= ADDR_RESET;
      oar_q <= ADDR_RESET;
      cnt_q <= COUNT_RESET;
      dxr_q <= DATA_RESET;
    end else begin
      if (wr_sar) sar_q <= i_io_wdata[ADDR_W-1:0];
      if (wr_oar) oar_q <= i_io_wdata[ADDR_W-1:0];
      if (wr_cnt) cnt_q <= i_io_wdata;
      if (wr_dxr) dxr_q <= i_io_wdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_int_q  <= 17'h0;
      drr_q      <= DATA_RESET;
      rdata_q    <= 16'h0000;
      dxr_full_q <= 1'b0;
      rx_rdy_q   <= 1'b0;
      aas_q      <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      if (wr_cnt) cnt_int_q <= cnt_load;
      else if (cnt_dec) cnt_int_q <= cnt_int_q - 17'h1;
      if (rx_copy) drr_q <= sh_data;
      if (rd) rdata_q <= rd_mux;
      dxr_full_q <= wr_dxr | (dxr_full_q & ~(ld & ld_dxr));
      rx_rdy_q   <= rx_copy | (rx_rdy_q & ~rd_drr);
      aas_q      <= aas_set | (aas_q & ~aas_clr);
      busy_q     <= start_det | (busy_q & ~stop_det);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      m_q     <= M_IDLE;
      div_q   <= 16'h0000;
      stp_ph_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      scl_s_q <= {scl_s_q[1:0], i_scl};
      sda_s_q <= {sda_s_q[1:0], i_sda};
      m_q     <= m_d;
      div_q   <= (tick | (m_d != m_q) | (m_q == M_IDLE) | (m_q == M_HOLD)) ? 16'h0000
                                                                           : div_q + 16'h1;
      stp_ph_q <= stp_ph_d;
      scl_oe_q <= scl_d;
      sda_oe_q <= sda_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      eng_q    <= 1'b0;
      ack_ph_q <= 1'b0;
      tx_q     <= 1'b0;
      slave_q  <= 1'b0;
      kind_q   <= K_DATA;
      bit_q    <= 4'h0;
      nack_q   <= 1'b0;
    end else begin
      if (ld) begin
        eng_q    <= 1'b1;
        ack_ph_q <= 1'b0;
        tx_q     <= ld_tx;
        slave_q  <= ld_slave;
        kind_q   <= ld_kind;
        bit_q    <= 4'h0;
      end else if (enter_ack) begin
        ack_ph_q <= 1'b1;
      end else if (byte_end | stop_det) begin
        eng_q    <= 1'b0;
        ack_ph_q <= 1'b0;
      end else if (sh_shift) begin
        bit_q <= bit_q + 4'h1;
      end
      if (eng_q & scl_rise & ack_ph_q) nack_q <= sda_now;
    end
  end

  assign o_io_rdata                = rdata_q;
  assign o_addressed_as_slave_flag = aas_q;
  assign o_rx_ready                = rx_rdy_q;
  assign o_tx_ready                = ~dxr_full_q;
  assign o_bus_busy                = busy_q;
  assign o_scl_oe                  = scl_oe_q;
  assign o_sda_oe                  = sda_oe_q;
  assign o_scl_o                   = 1'b0;
  assign o_sda_o                   = 1'b0;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_cnt_load: assert property (wr_cnt |=> cnt_int_q == $past(cnt_load))
    else $error("internal count not loaded from write");
  chk_cnt_kept: assert property (cnt_dec && !wr_cnt |=> $stable(cnt_q) &&
    cnt_int_q == $past(cnt_int_q) - 17'h1)
    else $error("count register changed or counter not decremented");
  chk_rm_ignored: assert property (i_repeat_mode_select && !wr_cnt |=>
    $stable(cnt_int_q))
    else $error("counter moved in repeat mode");
  chk_stop_last: assert property (m_end && kind_q == K_DATA && tx_q && !nack_q &&
    i_transmit_select && i_stop_request && cnt_last |=> m_q == M_STOP)
    else $error("no stop after final byte");
  chk_rsvd_zero: assert property (rd && i_io_addr != REG_BYTE_COUNT |=>
    o_io_rdata[15:10] == 6'h00)
    else $error("reserved bits read nonzero");
  chk_aas_stop: assert property (stop_det || (start_det && !xa) |=>
    !o_addressed_as_slave_flag)
    else $error("slave flag survived stop or restart");
  chk_aas_ten: assert property (s_end && xa && kind_q == K_ADDR2 && !s_hit |=>
    !o_addressed_as_slave_flag)
    else $error("slave flag kept after address mismatch");
  chk_aas_hit: assert property (s_end && kind_q == K_ADDR1 && !xa && !sh_data[0] &&
    sh_data[7:1] == oar_q[6:0] |=> o_addressed_as_slave_flag)
    else $error("own address not recognised");
  // free format loads data in this state, so only the address case is checked
  chk_gen_call: assert property (m_q == M_START && ld && gen_call &&
    !i_free_format_select |-> ld_val == 8'h00)
    else $error("general call byte wrong");
  chk_ten_first: assert property (m_q == M_START && ld && xa &&
    !i_free_format_select |-> ld_val == {TEN_BIT_PREFIX, sar_q[9:8], 1'b0})
    else $error("ten-bit first byte wrong");
  chk_drr_copy: assert property (rx_copy |=> drr_q == $past(sh_data) &&
    o_rx_ready ##1 $stable(drr_q) || rx_copy)
    else $error("received byte not copied");
  chk_dxr_taken: assert property (ld && ld_dxr && !wr_dxr |=> o_tx_ready)
    else $error("transmit byte not taken");

  cov_aas_set: cover property (aas_set);
  cov_stop: cover property (m_q == M_BYTE ##1 m_q == M_STOP);
  cov_rx_copy: cover property (rx_copy);
  cov_hold: cover property (m_q == M_HOLD);

endmodule : iacd_ctrl

// ---- rtl/iacd_pkg.sv ----
package iacd_pkg;

  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SCL_HALF_NS   = 2500;
  // longest half period, so the count rounds down
  localparam int unsigned SCL_HALF_CYC  = (SCL_HALF_NS * 1000) / CLK_PERIOD_PS;

  localparam int unsigned REG_AW = 3;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;

  localparam logic [REG_AW-1:0] REG_TARGET_ADDR = 3'h0;
  localparam logic [REG_AW-1:0] REG_OWN_ADDR    = 3'h1;
  localparam logic [REG_AW-1:0] REG_BYTE_COUNT  = 3'h2;
  localparam logic [REG_AW-1:0] REG_RX_DATA     = 3'h3;
  localparam logic [REG_AW-1:0] REG_TX_DATA     = 3'h4;

  localparam logic [ADDR_W-1:0] ADDR_RESET  = 10'h000;
  localparam logic [15:0]       COUNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;
  localparam logic [16:0]       COUNT_FULL  = 17'h10000;
  localparam logic [4:0]        TEN_BIT_PREFIX = 5'h1e;

  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_BYTE  = 3'b010,
    M_HOLD  = 3'b011,
    M_STOP  = 3'b100
  } iacd_mst_t;

  typedef enum logic [1:0] {
    K_ADDR1 = 2'b00,
    K_ADDR2 = 2'b01,
    K_DATA  = 2'b10
  } iacd_kind_t;

endpackage : iacd_pkg

// ---- rtl/iacd_shift.sv ----
`timescale 1ns/1ps
// one shift register serves both directions; it has no path to the register port
module iacd_shift #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_load_val,
  input  wire logic         i_shift,
  input  wire logic         i_bit,
  output logic      [W-1:0] o_data,
  output logic              o_msb
);

  logic [W-1:0] sh_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sh_q <= '0;
    end else if (i_load) begin
      sh_q <= i_load_val;
    end else if (i_shift) begin
      sh_q <= {sh_q[W-2:0], i_bit};
    end
  end

  assign o_data = sh_q;
  assign o_msb  = sh_q[W-1];

endmodule : iacd_shift

// ---- verif/iacd_peer.sv ----
`timescale 1ns/1ps
// far-side bus device: a slave that records every byte, plus a bit-banged master
module iacd_peer (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_oe,
  output logic      o_sda_oe
);
  logic [7:0] sh;
  logic [7:0] got[$];
  int         bits;
  logic       stopped;
  logic       drv;
  logic       m_scl;
  logic       m_sda;
  logic       a_sda;

  assign o_scl_oe = m_scl;
  assign o_sda_oe = m_sda | a_sda;

  initial begin
    drv = 1'b0;
    m_scl = 1'b0;
    m_sda = 1'b0;
    a_sda = 1'b0;
    stopped = 1'b0;
    bits = 0;
  end

  // start and stop are only seen while scl is high; the monitor sleeps while we drive
  always @(negedge i_sda) if (i_scl === 1'b1 && !drv) bits = 0;
  always @(posedge i_sda) if (i_scl === 1'b1 && !drv) stopped = 1'b1;
  always @(posedge i_scl) if (!drv) begin
    sh = {sh[6:0], i_sda};
    bits++;
    if (bits == 8) got.push_back(sh);
  end
  // ack slot: pull sda from the 8th scl fall to the 9th
  always @(negedge i_scl) if (!drv) begin
    if (bits == 8) a_sda = 1'b1;
    if (bits == 9) begin
      a_sda = 1'b0;
      bits = 0;
    end
  end

  task automatic clr;
    got.delete();
    stopped = 1'b0;
    bits = 0;
  endtask : clr

  // link clock 64 ns; data bits move sda mid-way through the low half, start and stop move it while scl is high
  task automatic m_start;
    drv = 1'b1;
    m_sda = 1'b0;
    #16 m_scl = 1'b0;
    #16 m_sda = 1'b1;
    #32 m_scl = 1'b1;
    #16;
  endtask : m_start

  task automatic m_bit(input logic b, output logic s);
    m_sda = !b;
    #16 m_scl = 1'b0;
    #16 s = i_sda;
    #16 m_scl = 1'b1;
    #16;
  endtask : m_bit

  task automatic m_byte(input logic [7:0] d, input int n, output logic ack);
    logic s;
    for (int i = n - 1; i >= 0; i--) m_bit(d[i], s);
    m_bit(1'b1, ack);
  endtask : m_byte

  task automatic m_stop;
    m_sda = 1'b1;
    #16 m_scl = 1'b0;
    #32 m_sda = 1'b0;
    #16 drv = 1'b0;
  endtask : m_stop
endmodule : iacd_peer

// ---- verif/iacd_ctrl_tb.sv ----
`timescale 1ns/1ps
module iacd_ctrl_tb;
  import iacd_pkg::*;
  typedef struct packed {logic [2:0] a; logic [15:0] d; logic [15:0] e;} iacd_row_t;
  logic        clk = 1'b0;
  logic        rst_n, sel, we, mst, go, transmit_select, ff, xa, rm, stop_request, ack;
  logic [2:0]  addr, blen;
  logic [15:0] wd, rdata, v;
  logic        addressed_as_slave_flag, rxr, txr, busy, scl_oe, sda_oe, p_scl, p_sda;
  wire         scl = !(scl_oe | p_scl);
  wire         sda = !(sda_oe | p_sda);
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [7:0]  exp_q[$];
  iacd_row_t   rows [8] = '{
    '{REG_TARGET_ADDR, 16'hffff, 16'h03ff}, '{REG_TARGET_ADDR, 16'h005a, 16'h005a},
    '{REG_OWN_ADDR, 16'hffff, 16'h03ff}, '{REG_BYTE_COUNT, 16'hffff, 16'hffff},
    '{REG_BYTE_COUNT, 16'h0000, 16'h0000}, '{REG_RX_DATA, 16'h1234, 16'h0000},
    '{3'h5, 16'habcd, 16'h0000}, '{3'h7, 16'hffff, 16'h0000}};

  always #2.5 clk = ~clk;

  iacd_ctrl #(.HALF_CYC(8)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_io_sel(sel), .i_io_we(we), .i_io_addr(addr),
    .i_io_wdata(wd), .o_io_rdata(rdata), .i_master(mst), .i_start_req(go),
    .i_transmit_select(transmit_select), .i_free_format_select(ff), .i_extended_address_select(xa),
    .i_repeat_mode_select(rm), .i_stop_request(stop_request), .i_bit_length_field(blen),
    .o_addressed_as_slave_flag(addressed_as_slave_flag), .o_rx_ready(rxr), .o_tx_ready(txr), .o_bus_busy(busy),
    .i_scl(scl), .o_scl_o(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(), .o_sda_oe(sda_oe));

  iacd_peer i_p (.i_scl(scl), .i_sda(sda), .o_scl_oe(p_scl), .o_sda_oe(p_sda));

  task automatic final_report;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // an idle edge after each access keeps the strobe from being set twice in one step
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    sel = 1'b1;
    we = 1'b1;
    addr = a;
    wd = d;
    @(posedge clk);
    #1 sel = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    sel = 1'b1;
    we = 1'b0;
    addr = a;
    @(posedge clk);
    #1 sel = 1'b0;
    d = rdata;
    @(posedge clk);
    #1;
  endtask : rd

  task automatic wait_on(input int s);
    int k;
    for (k = 0; k < 4000; k++) begin
      if ((s == 0 && txr === 1'b1) || (s == 1 && i_p.stopped)) break;
      @(posedge clk);
      #1;
    end
    if (k == 4000) begin
      n_fail++;
      $display("CHECK FAILED t=%0t wait %h expired %h", $time, s, k);
      final_report();
    end
  endtask : wait_on

  task automatic xfer(input logic x, f, input logic [9:0] t, input logic [15:0] c,
                      input logic [7:0] d);
    exp_q.delete();
    if (!f && x) exp_q = '{{5'h1e, t[9:8], 1'b0}, t[7:0]};
    if (!f && !x) exp_q = '{{t[6:0], 1'b0}};
    exp_q.push_back(d);
    if (c == 16'h2) exp_q.push_back(~d);
    xa = x;
    ff = f;
    mst = 1'b1;
    wr(REG_TARGET_ADDR, {6'h0, t});
    wr(REG_BYTE_COUNT, c);
    wr(REG_TX_DATA, {8'h0, d});
    i_p.clr();
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    if (c == 16'h2) begin
      wait_on(0);
      wr(REG_TX_DATA, {8'h0, ~d});
    end
    wait_on(1);
    repeat (8) @(posedge clk);
    #1;
    chk(16'(i_p.got.size()), 16'(exp_q.size()));
    foreach (exp_q[k]) chk({8'h0, i_p.got[k]}, {8'h0, exp_q[k]});
    chk({14'h0, busy, txr}, 16'h0001);
    rd(REG_BYTE_COUNT, v);
    chk(v, c);
    $display("test master transfer done");
  endtask : xfer

  task automatic sbyte(input logic [7:0] d, input int n, input logic e);
    i_p.m_byte(d, n, ack);
    chk(16'(ack), 16'(e));
  endtask : sbyte

  task automatic flag(input logic e);
    repeat (4) @(posedge clk);
    #1;
    chk(16'(addressed_as_slave_flag), 16'(e));
  endtask : flag

  initial begin
    {rst_n, sel, we, mst, go, ff, xa, rm, stop_request, ack} = '0;
    transmit_select = 1'b1;
    stop_request = 1'b1;
    addr = 3'h0;
    blen = 3'h0;
    wd = 16'h0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({12'h0, addressed_as_slave_flag, rxr, txr, busy}, 16'h0002);
    for (int a = 0; a < 5; a++) begin
      rd(3'(a), v);
      chk(v, 16'h0000);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    $display("test registers done");
    xfer(1'b0, 1'b0, 10'h05a, 16'h2, 8'hc3);
    xfer(1'b0, 1'b0, 10'h000, 16'h1, 8'h5a);
    xfer(1'b1, 1'b0, 10'h2b6, 16'h2, 8'h81);
    xfer(1'b1, 1'b1, 10'h3ff, 16'h1, 8'h7e);
    // repeat mode: count of five is ignored, stop follows the first data byte
    rm = 1'b1;
    xfer(1'b0, 1'b0, 10'h011, 16'h5, 8'h96);
    rm = 1'b0;
    // slave side, 7-bit: address, full byte, 3-bit byte, then a restart to a stranger
    mst = 1'b0;
    xa = 1'b0;
    wr(REG_OWN_ADDR, 16'h003c);
    i_p.m_start();
    sbyte(8'h78, 8, 1'b0);
    flag(1'b1);
    sbyte(8'ha5, 8, 1'b0);
    repeat (4) @(posedge clk);
    #1 chk(16'(rxr), 16'h1);
    rd(REG_RX_DATA, v);
    chk(v, 16'h00a5);
    chk(16'(rxr), 16'h0);
    blen = 3'h3;
    sbyte(8'h05, 3, 1'b0);
    repeat (4) @(posedge clk);
    #1 rd(REG_RX_DATA, v);
    chk(v & 16'hff07, 16'h0005);
    i_p.m_start();
    flag(1'b0);
    sbyte(8'h7a, 8, 1'b1);
    i_p.m_stop();
    // slave side, 10-bit: match then stop, then a second byte that differs
    blen = 3'h0;
    xa = 1'b1;
    wr(REG_OWN_ADDR, 16'h02a5);
    i_p.m_start();
    sbyte(8'hf4, 8, 1'b0);
    sbyte(8'ha5, 8, 1'b0);
    flag(1'b1);
    i_p.m_stop();
    flag(1'b0);
    i_p.m_start();
    sbyte(8'hf4, 8, 1'b0);
    sbyte(8'ha5, 8, 1'b0);
    // in 10-bit mode a restart keeps the flag; the mismatching byte clears it
    i_p.m_start();
    flag(1'b1);
    sbyte(8'hf4, 8, 1'b0);
    sbyte(8'ha4, 8, 1'b1);
    flag(1'b0);
    i_p.m_stop();
    $display("test slave receive done");
    final_report();
  end
endmodule : iacd_ctrl_tb
